// [logic/ebt_pkg.sv]
// Purpose: Shared constants, types and helpers of the eight-bit timer.
// Assumes: 32-bit APB, byte addresses, one register per aligned word.
// Notes: Operation
// Operation
// - Phase correct PWM period is 510 timer ticks.
// - Phase correct: compare 0x00 holds output low, 0xFF high; inverted opposite.
// - Phase correct output moves at bottom without match to keep symmetry.
// - Force strobe applies compare action in non-PWM modes only.
// - Force sets no flag, never clears counter, reads as zero.
// - Mode field is bit 3 high, bit 6 low: normal, phase PWM, clear, fast.
// - Top is 0xFF except clear mode; compare updates per mode timing.
// - Overflow flag at 0xFF, or at 0x00 reversal in phase correct mode.
// - Nonzero output mode overrides pin; pin drives only when direction is out.
// - Non-PWM output modes: disconnect, toggle, clear, set on match.
// - Fast PWM: 10 clear match set bottom, 11 inverse, 01 reserved.
// - Fast PWM with compare at top ignores match, acts only at bottom.
// - Phase correct: 10 clear on up match, set on down match; 11 inverse.
// - Phase correct with compare at top ignores match, acts at top.
// - Clock select: stop, direct, /8, /64, /256, /1024, pin fall, pin rise.
// - External pin edges clock the counter even if pin is an output.
// - Counter is read-write; a write blocks the next tick's match.
// - Compare register is compared with counter continuously.
// - Mask bit1 compare enable, bit0 overflow; request needs flag and global enable.
// - Compare flag bit1 sets on match; clears by vector or written one.
// - Overflow flag bit0 clears by vector or written one; zero ignored.
// - Clear mode resets counter to zero on compare match.
// - Phase correct counts up to 0xFF then down, one tick at max.
// - Fast PWM counts to 0xFF then restarts at zero.
package ebt_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_COMPARE = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_PIN_CTRL = 8'h38;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int BIT_FORCE = 7;
  localparam int BIT_CMP = 1;
  localparam int BIT_OVF = 0;
  localparam int BIT_GIE = 0;
  localparam int BIT_DIR_OUT = 1;
  localparam int BIT_PORT_LVL = 2;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;
  localparam logic [1:0] MODE_FAST = 2'h3;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_PIN_FALL = 3'h6;
  localparam logic [2:0] CS_PIN_RISE = 3'h7;
  localparam int PRE_W = 10;
  localparam logic [9:0] PHASE_PERIOD = 10'h1FE;

  typedef struct packed {
    logic force_compare_strobe;
    logic wave_mode_lo;
    logic [1:0] compare_out_mode;
    logic wave_mode_hi;
    logic [2:0] clock_source_sel;
  } ebt_ctrl_t;

  typedef enum logic {EBT_UP, EBT_DOWN} ebt_dir_t;

  function automatic logic [1:0] wave_mode_sel(input ebt_ctrl_t c);
    return {c.wave_mode_hi, c.wave_mode_lo};
  endfunction : wave_mode_sel

  function automatic logic is_pwm(input logic [1:0] m);
    return (m == MODE_PHASE) || (m == MODE_FAST);
  endfunction : is_pwm

  // Non-PWM compare action on the output level.
  function automatic logic nonpwm_action(input logic [1:0] com, input logic oc);
    case (com)
      2'h1: return !oc;
      2'h2: return 1'b0;
      2'h3: return 1'b1;
      default: return oc;
    endcase
  endfunction : nonpwm_action
endpackage : ebt_pkg

// [logic/ebt_tick_sel.sv]
// Purpose: Timer tick source: free-running prescaler taps and external pin edges.
// Assumes: External pin is asynchronous and slower than half the bus clock.
// Notes: The tick is one registered pulse per counting event.
`timescale 1ns/1ns
module ebt_tick_sel
  import ebt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] clock_source_sel,
  input wire logic external_count_pin,
  output logic timer_tick
);
  logic [PRE_W-1:0] pre_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic tick_reg;
  wire logic rise = sync2_reg && !prev_reg;
  wire logic fall = !sync2_reg && prev_reg;
  wire logic tap8 = &pre_reg[2:0];
  wire logic tap64 = &pre_reg[5:0];
  wire logic tap256 = &pre_reg[7:0];
  wire logic tap1024 = &pre_reg[9:0];
  logic tick_next;

  always_comb begin
    case (clock_source_sel)
      CS_DIRECT: tick_next = 1'b1;
      CS_DIV8: tick_next = tap8;
      CS_DIV64: tick_next = tap64;
      CS_DIV256: tick_next = tap256;
      CS_DIV1024: tick_next = tap1024;
      CS_PIN_FALL: tick_next = fall;
      CS_PIN_RISE: tick_next = rise;
      default: tick_next = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
      sync1_reg <= external_count_pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      tick_reg <= tick_next;
    end
  end

  assign timer_tick = tick_reg;
endmodule : ebt_tick_sel

// [logic/ebt_timer.sv]
// Purpose: Eight-bit timer with one compare channel behind an APB slave.
// Assumes: Zero-wait APB answer one cycle after setup; 50 MHz pclk.
// Notes: Vector acknowledge inputs clear flags like a written one.
`timescale 1ns/1ns
module ebt_timer
  import ebt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_pin,
  input wire logic compare_vector_ack,
  input wire logic overflow_vector_ack,
  output logic compare_irq_req,
  output logic overflow_irq_req,
  output logic compare_output_pin_o,
  output logic compare_output_pin_oe_n
);
  ebt_ctrl_t ctrl_reg;
  logic [7:0] count_value_reg;
  logic [7:0] compare_level_reg;
  logic [7:0] cmp_act_reg;
  logic [1:0] mask_reg;
  logic [1:0] flag_reg;
  logic [2:0] pin_ctrl_reg;
  ebt_dir_t dir_reg;
  logic block_reg;
  logic oc_reg;
  logic pin_o_reg;
  logic pin_oe_n_reg;
  logic cmp_irq_reg;
  logic ovf_irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic timer_tick;

  logic [7:0] count_value_next;
  ebt_dir_t dir_next;
  logic ovf_evt;
  logic oc_next;
  logic [7:0] cmp_act_next;
  logic [31:0] rd_mux;

  ebt_tick_sel u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clock_source_sel(ctrl_reg.clock_source_sel),
    .external_count_pin(external_count_pin),
    .timer_tick(timer_tick)
  );

  // Bus decode.
  wire logic setup = psel && !penable;
  wire logic wr_acc = psel && penable && pready_reg && pwrite;
  wire logic sel_ctrl = paddr == OFF_CONTROL;
  wire logic sel_cnt = paddr == OFF_COUNT;
  wire logic sel_cmp = paddr == OFF_COMPARE;
  wire logic sel_mask = paddr == OFF_MASK;
  wire logic sel_flag = paddr == OFF_FLAGS;
  wire logic sel_pin = paddr == OFF_PIN_CTRL;
  wire logic mapped = sel_ctrl || sel_cnt || sel_cmp || sel_mask || sel_flag || sel_pin;
  wire logic wr_ok = wr_acc && mapped;
  wire ebt_ctrl_t wr_ctrl = ebt_ctrl_t'(pwdata[7:0]);
  wire logic wr_cnt = wr_ok && sel_cnt;

  // Counter view.
  wire logic [1:0] mode = wave_mode_sel(ctrl_reg);
  wire logic [1:0] com = ctrl_reg.compare_out_mode;
  wire logic top_hit = count_value_reg == CNT_MAX;
  wire logic bot_hit = count_value_reg == CNT_BOTTOM;
  wire logic cmp_max = cmp_act_reg == CNT_MAX;
  wire logic cmp_zero = cmp_act_reg == CNT_BOTTOM;
  wire logic match = timer_tick && (count_value_reg == cmp_act_reg) && !block_reg;
  wire logic force_hit = wr_ok && sel_ctrl && wr_ctrl.force_compare_strobe &&
                         !is_pwm(wave_mode_sel(wr_ctrl));
  wire logic connected = |com;
  wire logic [1:0] flag_set = {match, ovf_evt};
  wire logic [1:0] flag_clr = ({2{wr_ok && sel_flag}} & pwdata[1:0]) |
                              {compare_vector_ack, overflow_vector_ack};
  wire logic [1:0] flag_next = flag_set | (flag_reg & ~flag_clr);
  wire logic block_next = wr_cnt ? 1'b1 : (timer_tick ? 1'b0 : block_reg);
  wire logic [1:0] req_next = flag_next & mask_reg & {2{pin_ctrl_reg[BIT_GIE]}};

  always_comb begin
    count_value_next = count_value_reg;
    dir_next = dir_reg;
    ovf_evt = 1'b0;
    if (wr_cnt) begin
      count_value_next = pwdata[7:0];
    end else if (timer_tick) begin
      case (mode)
        MODE_NORMAL, MODE_FAST: begin
          count_value_next = count_value_reg + 8'h01;
          ovf_evt = top_hit;
        end
        MODE_CLEAR: begin
          count_value_next = match ? CNT_BOTTOM : count_value_reg + 8'h01;
          ovf_evt = top_hit;
        end
        MODE_PHASE: begin
          if (dir_reg == EBT_UP) begin
            if (top_hit) begin
              dir_next = EBT_DOWN;
              count_value_next = count_value_reg - 8'h01;
            end else begin
              count_value_next = count_value_reg + 8'h01;
            end
          end else if (bot_hit) begin
            dir_next = EBT_UP;
            count_value_next = count_value_reg + 8'h01;
            ovf_evt = 1'b1;
          end else begin
            count_value_next = count_value_reg - 8'h01;
          end
        end
        default: count_value_next = count_value_reg;
      endcase
    end
  end

  always_comb begin
    oc_next = oc_reg;
    if (force_hit) begin
      oc_next = nonpwm_action(wr_ctrl.compare_out_mode, oc_reg);
    end else if (timer_tick) begin
      case (mode)
        MODE_NORMAL, MODE_CLEAR: begin
          if (match) begin
            oc_next = nonpwm_action(com, oc_reg);
          end
        end
        MODE_FAST: begin
          if (com[1]) begin
            if (match && !cmp_max) begin
              oc_next = com[0];
            end
            if (top_hit) begin
              oc_next = !com[0];
            end
          end
        end
        MODE_PHASE: begin
          if (com[1]) begin
            if (match) begin
              oc_next = (dir_reg == EBT_UP) ? com[0] : !com[0];
            end
            if (dir_reg == EBT_UP && top_hit) begin
              oc_next = cmp_max ? !com[0] : com[0];
            end
            if (dir_reg == EBT_DOWN && bot_hit) begin
              oc_next = cmp_zero ? com[0] : !com[0];
            end
          end
        end
        default: oc_next = oc_reg;
      endcase
    end
  end

  // Compare buffer reaches the comparator per mode.
  always_comb begin
    cmp_act_next = cmp_act_reg;
    case (mode)
      MODE_PHASE: begin
        if (timer_tick && dir_reg == EBT_UP && top_hit) begin
          cmp_act_next = compare_level_reg;
        end
      end
      MODE_FAST: begin
        if (timer_tick && top_hit) begin
          cmp_act_next = compare_level_reg;
        end
      end
      default: cmp_act_next = compare_level_reg;
    endcase
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      sel_ctrl: rd_mux[7:0] = {1'b0, ctrl_reg[6:0]};
      sel_cnt: rd_mux[7:0] = count_value_reg;
      sel_cmp: rd_mux[7:0] = compare_level_reg;
      sel_mask: rd_mux[1:0] = mask_reg;
      sel_flag: rd_mux[1:0] = flag_reg;
      sel_pin: rd_mux[2:0] = pin_ctrl_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ebt_ctrl_t'(RST_CONTROL);
      compare_level_reg <= RST_BYTE;
      mask_reg <= RST_BYTE[1:0];
      pin_ctrl_reg <= RST_BYTE[2:0];
    end else if (wr_ok) begin
      if (sel_ctrl) ctrl_reg <= ebt_ctrl_t'({1'b0, pwdata[6:0]});
      if (sel_cmp) compare_level_reg <= pwdata[7:0];
      if (sel_mask) mask_reg <= pwdata[1:0];
      if (sel_pin) pin_ctrl_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_reg <= RST_BYTE;
      cmp_act_reg <= RST_BYTE;
      dir_reg <= EBT_UP;
      block_reg <= 1'b0;
      flag_reg <= RST_BYTE[1:0];
      oc_reg <= 1'b0;
    end else begin
      count_value_reg <= count_value_next;
      cmp_act_reg <= cmp_act_next;
      dir_reg <= dir_next;
      block_reg <= block_next;
      flag_reg <= flag_next;
      oc_reg <= oc_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      cmp_irq_reg <= 1'b0;
      ovf_irq_reg <= 1'b0;
    end else begin
      pin_o_reg <= connected ? oc_reg : pin_ctrl_reg[BIT_PORT_LVL];
      pin_oe_n_reg <= !pin_ctrl_reg[BIT_DIR_OUT];
      cmp_irq_reg <= req_next[BIT_CMP];
      ovf_irq_reg <= req_next[BIT_OVF];
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign compare_irq_req = cmp_irq_reg;
  assign overflow_irq_req = ovf_irq_reg;
  assign compare_output_pin_o = pin_o_reg;
  assign compare_output_pin_oe_n = pin_oe_n_reg;

  // Counts timer ticks between phase-mode bottom turns so the full period can be checked.
  logic [9:0] phase_ticks_reg;
  logic phase_seen_reg;
  wire logic phase_turn = timer_tick && !wr_cnt && mode == MODE_PHASE &&
                          dir_reg == EBT_DOWN && bot_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ticks_reg <= 10'h000;
      phase_seen_reg <= 1'b0;
    end else if (mode != MODE_PHASE || wr_cnt) begin
      phase_ticks_reg <= 10'h000;
      phase_seen_reg <= 1'b0;
    end else if (phase_turn) begin
      phase_ticks_reg <= 10'h000;
      phase_seen_reg <= 1'b1;
    end else if (timer_tick) begin
      phase_ticks_reg <= phase_ticks_reg + 10'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strobe_reads_zero_a: assert property (
    setup && !pwrite && sel_ctrl |=> prdata[BIT_FORCE] == 1'b0)
    else $error("force strobe read back as one");
  overflow_flag_set_a: assert property (
    timer_tick && !wr_cnt && mode != MODE_PHASE && top_hit |=> flag_reg[BIT_OVF])
    else $error("overflow flag missed at max");
  phase_bottom_ovf_a: assert property (
    timer_tick && !wr_cnt && mode == MODE_PHASE && dir_reg == EBT_DOWN && bot_hit
    |=> flag_reg[BIT_OVF] && dir_reg == EBT_UP && count_value_reg == 8'h01)
    else $error("phase mode bottom reversal wrong");
  clear_on_match_a: assert property (
    match && !wr_cnt && mode == MODE_CLEAR |=> count_value_reg == CNT_BOTTOM)
    else $error("clear mode did not zero counter");
  phase_top_turn_a: assert property (
    timer_tick && !wr_cnt && mode == MODE_PHASE && dir_reg == EBT_UP && top_hit
    |=> count_value_reg == 8'hFE && dir_reg == EBT_DOWN)
    else $error("phase mode top reversal wrong");
  wrap_to_zero_a: assert property (
    timer_tick && !wr_cnt && (mode == MODE_FAST || mode == MODE_NORMAL) && top_hit
    |=> count_value_reg == CNT_BOTTOM)
    else $error("counter did not wrap");
  write_blocks_match_a: assert property (
    block_reg && timer_tick && !flag_reg[BIT_CMP] |=> !flag_reg[BIT_CMP])
    else $error("match not blocked after counter write");
  count_write_arms_a: assert property (
    wr_cnt |=> block_reg)
    else $error("counter write did not arm match block");
  force_no_flag_a: assert property (
    force_hit && !match && !flag_reg[BIT_CMP] |=> !flag_reg[BIT_CMP])
    else $error("forced compare set the flag");
  irq_request_a: assert property (
    ##1 compare_irq_req == $past(flag_next[BIT_CMP] && mask_reg[BIT_CMP] &&
    pin_ctrl_reg[BIT_GIE]))
    else $error("compare request wrong");
  flag_clear_a: assert property (
    wr_ok && sel_flag && pwdata[BIT_OVF] && !ovf_evt |=> !flag_reg[BIT_OVF])
    else $error("overflow flag not cleared");
  pin_release_a: assert property (
    !connected ##1 !connected |-> pin_o_reg == $past(pin_ctrl_reg[BIT_PORT_LVL]))
    else $error("pin not returned to port level");
  phase_period_a: assert property (
    phase_turn && phase_seen_reg |-> phase_ticks_reg == PHASE_PERIOD - 10'h001)
    else $error("phase mode period wrong");
  fast_bottom_act_a: assert property (
    timer_tick && !force_hit && mode == MODE_FAST && com[1] && top_hit
    |=> oc_reg != $past(com[0]))
    else $error("fast mode bottom action wrong");
  force_action_a: assert property (
    force_hit && wr_ctrl.compare_out_mode == 2'h3 |=> oc_reg)
    else $error("forced set did not drive output high");
  count_holds_a: assert property (
    !timer_tick && !wr_cnt |=> $stable(count_value_reg))
    else $error("counter moved without a tick");
  stop_no_tick_a: assert property (
    ctrl_reg.clock_source_sel == CS_STOP |=> !timer_tick)
    else $error("tick while clock stopped");

  phase_mode_run_c: cover property (mode == MODE_PHASE && timer_tick && bot_hit);
  fast_pwm_run_c: cover property (mode == MODE_FAST && com[1] && match);
  force_strobe_c: cover property (force_hit);
  unmapped_c: cover property (pslverr);
  clear_match_c: cover property (mode == MODE_CLEAR && match);
endmodule : ebt_timer

// [tb/ebt_timer_bench.sv]
// Purpose: Self-checking bench for the eight-bit timer through APB and its pins.
// Assumes: Zero-wait APB slave, 50 MHz pclk, register map of ebt_pkg.
// Notes: Waveforms are judged by high cycles and rising edges over whole periods.
`timescale 1ns/1ns
module ebt_timer_bench import ebt_pkg::*;;
  typedef struct {
    logic [1:0] m;
    logic [1:0] com;
    logic [7:0] cmp;
    int win;
    int hi;
    int rises;
  } ebt_case_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic ext_pin, cmp_ack, ovf_ack, cmp_irq, ovf_irq, pin_o, pin_oe_n;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt, tests_run, cyc, hi, rises;

  ebt_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_pin(ext_pin), .compare_vector_ack(cmp_ack),
    .overflow_vector_ack(ovf_ack), .compare_irq_req(cmp_irq), .overflow_irq_req(ovf_irq),
    .compare_output_pin_o(pin_o), .compare_output_pin_oe_n(pin_oe_n));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic summarize();
    $display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // A run past 80000 cycles ends here as a failure; apb gives up on pready after 40 cycles.
  always @(posedge pclk) begin
    cyc++;
    if (cyc >= 80000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string name, input int lo, input int hi_lim,
      input logic [31:0] got);
    tests_run++;
    if ($isunknown(got) || got < lo || got > hi_lim) begin
      error_cnt++;
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi_lim, got);
    end
  endtask : chk_rng

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    last_err = pslverr;
    if (n >= 40) chk("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge pclk);
  endtask : wr

  task automatic rdreg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rdreg

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] com,
      input logic [2:0] cs, input logic f);
    ebt_ctrl_t c;
    c = '{force_compare_strobe: f, wave_mode_lo: m[0], compare_out_mode: com,
          wave_mode_hi: m[1], clock_source_sel: cs};
    return {24'h000000, c};
  endfunction : ctl

  task automatic measure(input int n);
    logic prev;
    hi = 0;
    rises = 0;
    prev = pin_o;
    repeat (n) begin
      @(posedge pclk);
      if (pin_o === 1'b1) hi++;
      if (pin_o === 1'b1 && prev === 1'b0) rises++;
      prev = pin_o;
    end
  endtask : measure

  task automatic t_reset();
    logic [7:0] offs [6];
    offs = '{OFF_CONTROL, OFF_COUNT, OFF_COMPARE, OFF_MASK, OFF_FLAGS, OFF_PIN_CTRL};
    chk("pin enable at reset", 32'h1, pin_oe_n);
    foreach (offs[i]) begin
      rdreg(offs[i]);
      chk("reset value", 32'h0, rd);
      chk("slave error", 32'h0, last_err);
    end
    rdreg(8'h3C);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped error", 32'h1, last_err);
    $display("test reset done");
  endtask : t_reset

  task automatic t_normal();
    wr(OFF_COUNT, 32'hF0);
    wr(OFF_COMPARE, 32'hF8);
    wr(OFF_CONTROL, ctl(MODE_NORMAL, 2'h0, CS_DIRECT, 1'b0));
    repeat (30) @(posedge pclk);
    wr(OFF_CONTROL, 32'h0);
    rdreg(OFF_COUNT);
    chk_rng("count after wrap", 14, 23, rd);
    rdreg(OFF_FLAGS);
    chk("flags", 32'h3, rd);
    wr(OFF_MASK, 32'h1);
    chk("overflow irq without global", 32'h0, ovf_irq);
    wr(OFF_PIN_CTRL, 32'h1);
    chk("overflow irq", 32'h1, ovf_irq);
    chk("compare irq masked", 32'h0, cmp_irq);
    wr(OFF_FLAGS, 32'h0);
    rdreg(OFF_FLAGS);
    chk("flags after zero write", 32'h3, rd);
    ovf_ack <= 1'b1;
    @(posedge pclk);
    ovf_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("overflow irq after vector", 32'h0, ovf_irq);
    wr(OFF_MASK, 32'h2);
    chk("compare irq", 32'h1, cmp_irq);
    wr(OFF_FLAGS, 32'h2);
    rdreg(OFF_FLAGS);
    chk("flags cleared", 32'h0, rd);
    chk("compare irq cleared", 32'h0, cmp_irq);
    $display("test normal done");
  endtask : t_normal

  task automatic t_block();
    wr(OFF_COMPARE, 32'h80);
    wr(OFF_COUNT, 32'h0);
    wr(OFF_CONTROL, ctl(MODE_NORMAL, 2'h0, CS_DIRECT, 1'b0));
    wr(OFF_COUNT, 32'h80);
    repeat (4) @(posedge pclk);
    wr(OFF_CONTROL, 32'h0);
    rdreg(OFF_FLAGS);
    chk("match after count write", 32'h0, rd);
    rdreg(OFF_COUNT);
    chk_rng("count after write", 129, 140, rd);
    $display("test block done");
  endtask : t_block

  task automatic t_ctc();
    wr(OFF_COMPARE, 32'h10);
    wr(OFF_COUNT, 32'h0);
    wr(OFF_PIN_CTRL, 32'h2);
    wr(OFF_CONTROL, ctl(MODE_CLEAR, 2'h1, CS_DIRECT, 1'b0));
    chk("pin driven", 32'h0, pin_oe_n);
    repeat (100) @(posedge pclk);
    measure(340);
    chk("toggle high cycles", 32'd170, hi);
    chk("toggle periods", 32'd10, rises);
    repeat (6) begin
      rdreg(OFF_COUNT);
      chk_rng("count under top", 0, 16, rd);
    end
    wr(OFF_CONTROL, 32'h0);
    rdreg(OFF_FLAGS);
    chk("flags in clear mode", 32'h2, rd);
    cmp_ack <= 1'b1;
    @(posedge pclk);
    cmp_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    rdreg(OFF_FLAGS);
    chk("flags after vector", 32'h0, rd);
    $display("test clear mode done");
  endtask : t_ctc

  task automatic t_force();
    wr(OFF_COUNT, 32'h5);
    wr(OFF_CONTROL, ctl(MODE_CLEAR, 2'h3, CS_STOP, 1'b1));
    chk("forced set", 32'h1, pin_o);
    rdreg(OFF_CONTROL);
    chk("strobe reads zero", ctl(MODE_CLEAR, 2'h3, CS_STOP, 1'b0), rd);
    rdreg(OFF_COUNT);
    chk("count kept", 32'h5, rd);
    rdreg(OFF_FLAGS);
    chk("no flag on force", 32'h0, rd);
    wr(OFF_CONTROL, ctl(MODE_CLEAR, 2'h2, CS_STOP, 1'b1));
    chk("forced clear", 32'h0, pin_o);
    wr(OFF_CONTROL, ctl(MODE_NORMAL, 2'h1, CS_STOP, 1'b1));
    chk("forced toggle", 32'h1, pin_o);
    $display("test force done");
  endtask : t_force

  task automatic t_pwm();
    ebt_case_t cs [8];
    cs = '{'{MODE_FAST, 2'h2, 8'h40, 512, 130, 2}, '{MODE_FAST, 2'h3, 8'h40, 512, 382, 2},
           '{MODE_FAST, 2'h2, 8'hFF, 512, 512, 0}, '{MODE_PHASE, 2'h2, 8'h80, 1020, 512, 2},
           '{MODE_PHASE, 2'h3, 8'h80, 1020, 508, 2}, '{MODE_PHASE, 2'h2, 8'h00, 1020, 0, 0},
           '{MODE_PHASE, 2'h2, 8'hFF, 1020, 1020, 0}, '{MODE_PHASE, 2'h3, 8'h00, 1020, 1020, 0}};
    foreach (cs[i]) begin
      wr(OFF_COMPARE, {24'h000000, cs[i].cmp});
      wr(OFF_CONTROL, ctl(cs[i].m, cs[i].com, CS_DIRECT, 1'b0));
      repeat (1100) @(posedge pclk);
      measure(cs[i].win);
      chk("pwm high cycles", cs[i].hi, hi);
      chk("pwm periods", cs[i].rises, rises);
    end
    wr(OFF_CONTROL, 32'h0);
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_presc();
    int div [5];
    div = '{1, 8, 64, 256, 1024};
    foreach (div[i]) begin
      wr(OFF_COUNT, 32'h0);
      wr(OFF_CONTROL, ctl(MODE_NORMAL, 2'h0, 3'(i + 1), 1'b0));
      repeat (4 * div[i]) @(posedge pclk);
      wr(OFF_CONTROL, 32'h0);
      rdreg(OFF_COUNT);
      chk_rng("prescaled count", 3, 5 + 10 / div[i], rd);
    end
    $display("test prescale done");
  endtask : t_presc

  task automatic t_ext();
    logic [2:0] sel [2];
    sel = '{CS_PIN_FALL, CS_PIN_RISE};
    foreach (sel[i]) begin
      wr(OFF_COUNT, 32'h0);
      wr(OFF_CONTROL, ctl(MODE_NORMAL, 2'h0, sel[i], 1'b0));
      repeat (10) begin
        repeat (6) @(posedge pclk);
        ext_pin <= ~ext_pin;
      end
      repeat (8) @(posedge pclk);
      wr(OFF_CONTROL, 32'h0);
      rdreg(OFF_COUNT);
      chk("pin edge count", 32'h5, rd);
    end
    $display("test external done");
  endtask : t_ext

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ext_pin = 1'b0;
    cmp_ack = 1'b0;
    ovf_ack = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_normal();
    t_block();
    t_ctc();
    t_force();
    t_pwm();
    t_presc();
    t_ext();
    summarize();
  end
endmodule : ebt_timer_bench
